// >>> src/sbi_map.svh
// Purpose: constants for the bus slave interface (ack codes, size codes, timing)
// Assumes: included by bare name from the design file
// Notes: definitions only
`ifndef SBI_MAP_SVH
`define SBI_MAP_SVH
`define SBI_ACK_IDLE 3'h7
`define SBI_ACK_WAIT 3'h6
`define SBI_ACK_ERR 3'h5
`define SBI_ACK_WORD 3'h4
`define SBI_SIZ_BURST_BIT 2
`define SBI_SIZ_BURST_MIN 3'h4
`define SBI_SIZ_BURST_MAX 3'h6
`define SBI_CFG_ADDR 24'h000000
`define SBI_CFG_SENSE_LSB 0
`define SBI_CORE_LAT 3'h2
`endif

// >>> src/sbi_pkg.sv
// Purpose: types for the bus slave interface
// Assumes: nothing
// Notes: states of the link-side sequencer
package sbi_pkg;
    typedef enum logic [2:0] {
        SBI_IDLE,
        SBI_WAITCORE,
        SBI_ACK1,
        SBI_ACK2,
        SBI_RELEASE
    } sbi_state_e;
    typedef logic [31:0] sbi_word_t;
endpackage : sbi_pkg

// >>> src/sbi_slave.sv
// Purpose: slave side of the system bus, single accesses, with core handshake
// Assumes: bus clock sampled by clk (200 MHz) through two flip-flops
// Notes: access memory is a small word array standing for the core
`timescale 1ns/10ps
`default_nettype none
`include "sbi_map.svh"
module sbi_slave
    import sbi_pkg::*;
#(
    parameter int unsigned MEM_WORDS = 64 // core word storage depth
) (
    input wire logic clk, // core clock, 200 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic bus_clock_in, // bus clock pin
    input wire logic bus_reset_in, // bus reset pin, active high
    input wire logic slave_select_in, // slave select, active high
    input wire logic addr_strobe_in, // address strobe, active high
    input wire logic read_not_write_in, // 1 read, 0 write
    input wire logic [2:0] xfer_size_in, // access size code
    input wire logic [23:0] bus_addr_in, // access address
    input wire logic [31:0] bus_data_in, // data pins, input side
    output logic [31:0] bus_data_out, // data pins, output side
    output logic bus_data_oe_n, // data drive enable, low drives
    output logic [2:0] xfer_ack_out, // acknowledge code
    output logic xfer_ack_oe_n, // ack drive enable, low drives
    input wire logic vertical_blank_event, // vertical_blank_event level from timing
    output logic vertical_blank_event_irq_out, // interrupt pin value, always 0
    output logic vertical_blank_event_irq_oe_n, // low pulls the interrupt line
    input wire logic [2:0] monitor_sense_code // monitor sense pins
);
    localparam int unsigned AW = $clog2(MEM_WORDS);

    // two-flop synchronisers for every pin input
    logic [1:0] clk_s_q, rst_s_q, sel_s_q, as_s_q, rd_s_q, vb_s_q;
    logic [2:0] siz_m_q, siz_s_q, id_m_q, id_s_q;
    logic [23:0] adr_m_q, adr_s_q;
    logic [31:0] dat_m_q, dat_s_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_s_q <= 2'h0;
            rst_s_q <= 2'h3;
            sel_s_q <= 2'h0;
            as_s_q <= 2'h0;
            rd_s_q <= 2'h0;
            vb_s_q <= 2'h0;
            siz_m_q <= 3'h0;
            siz_s_q <= 3'h0;
            id_m_q <= 3'h0;
            id_s_q <= 3'h0;
            adr_m_q <= 24'h000000;
            adr_s_q <= 24'h000000;
            dat_m_q <= 32'h00000000;
            dat_s_q <= 32'h00000000;
        end else begin
            clk_s_q <= {clk_s_q[0], bus_clock_in};
            rst_s_q <= {rst_s_q[0], bus_reset_in};
            sel_s_q <= {sel_s_q[0], slave_select_in};
            as_s_q <= {as_s_q[0], addr_strobe_in};
            rd_s_q <= {rd_s_q[0], read_not_write_in};
            vb_s_q <= {vb_s_q[0], vertical_blank_event};
            siz_m_q <= xfer_size_in;
            siz_s_q <= siz_m_q;
            id_m_q <= monitor_sense_code;
            id_s_q <= id_m_q;
            adr_m_q <= bus_addr_in;
            adr_s_q <= adr_m_q;
            dat_m_q <= bus_data_in;
            dat_s_q <= dat_m_q;
        end
    end

    // edge detection on the synchronised bus clock and vertical_blank_event
    logic bclk_d1_q, vb_d1_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_d1_q <= 1'b0;
            vb_d1_q <= 1'b0;
        end else begin
            bclk_d1_q <= clk_s_q[1];
            vb_d1_q <= vb_s_q[1];
        end
    end
    wire logic bus_rise = clk_s_q[1] & ~bclk_d1_q;
    wire logic bus_rst = rst_s_q[1];
    wire logic sel_hit = sel_s_q[1] & as_s_q[1];

    // burst size codes are those with the top size bit set, up to the maximum
    function automatic logic is_burst(input logic [2:0] siz);
        is_burst = (siz >= `SBI_SIZ_BURST_MIN) && (siz <= `SBI_SIZ_BURST_MAX);
    endfunction : is_burst

    // link-side sequencer, advances only on bus clock rising edges
    sbi_state_e state_q;
    logic req_q, ack_s1_q, ack_s2_q, err_q, rd_q, drive_q;
    logic [23:0] addr_q;
    logic [31:0] wdata_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SBI_IDLE;
            req_q <= 1'b0;
            err_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 24'h000000;
            wdata_q <= 32'h00000000;
        end else if (bus_rst) begin
            state_q <= SBI_IDLE;
            req_q <= 1'b0;
            err_q <= 1'b0;
        end else if (bus_rise) begin
            case (state_q)
                SBI_IDLE: begin
                    if (sel_hit) begin
                        rd_q <= rd_s_q[1];
                        addr_q <= adr_s_q;
                        wdata_q <= dat_s_q;
                        if (is_burst(siz_s_q)) begin
                            err_q <= 1'b1;
                            state_q <= SBI_ACK1;
                        end else begin
                            err_q <= 1'b0;
                            req_q <= ~req_q;
                            state_q <= SBI_WAITCORE;
                        end
                    end
                end
                SBI_WAITCORE: begin
                    if (ack_s2_q == req_q) state_q <= SBI_ACK1;
                end
                SBI_ACK1: state_q <= SBI_ACK2;
                SBI_ACK2: state_q <= SBI_RELEASE;
                SBI_RELEASE: begin
                    if (!sel_hit) state_q <= SBI_IDLE; // wait for strobe to drop
                end
                default: state_q <= SBI_IDLE;
            endcase
        end
    end

    // core side: toggle request handled after a fixed latency, toggle ack back
    logic [MEM_WORDS*0+31:0] unused_w;
    logic req_c1_q, req_c2_q, req_c3_q, ack_tog_q;
    logic [2:0] lat_q;
    logic busy_q;
    sbi_word_t mem_q [MEM_WORDS];
    sbi_word_t rdata_q;
    assign unused_w = 32'h00000000;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_c1_q <= 1'b0;
            req_c2_q <= 1'b0;
            req_c3_q <= 1'b0;
            ack_tog_q <= 1'b0;
            lat_q <= 3'h0;
            busy_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            req_c1_q <= req_q;
            req_c2_q <= req_c1_q;
            req_c3_q <= req_c2_q;
            if (bus_rst) begin
                busy_q <= 1'b0;
                ack_tog_q <= req_c2_q;
            end else if (req_c2_q != req_c3_q) begin
                busy_q <= 1'b1;
                lat_q <= `SBI_CORE_LAT;
            end else if (busy_q) begin
                if (lat_q != 3'h0) begin
                    lat_q <= lat_q - 3'h1;
                end else begin
                    busy_q <= 1'b0;
                    if (addr_q == `SBI_CFG_ADDR) begin
                        rdata_q <= 32'h00000000;
                        rdata_q[`SBI_CFG_SENSE_LSB +: 3] <= id_s_q;
                    end else begin
                        rdata_q <= mem_q[addr_q[AW+1:2]];
                    end
                    ack_tog_q <= req_c2_q;
                end
            end
        end
    end

    // storage write, no reset needed for the array
    always_ff @(posedge clk) begin
        if (busy_q && lat_q == 3'h0 && !rd_q && addr_q != `SBI_CFG_ADDR)
            mem_q[addr_q[AW+1:2]] <= wdata_q;
    end

    // ack toggle back to the link side through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tog_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // pin drivers, all registered; ack driven only in its two closing cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_ack_out <= `SBI_ACK_IDLE;
            xfer_ack_oe_n <= 1'b1;
            bus_data_out <= 32'h00000000;
            bus_data_oe_n <= 1'b1;
            drive_q <= 1'b0;
        end else begin
            drive_q <= (state_q == SBI_ACK1) || (state_q == SBI_ACK2);
            xfer_ack_oe_n <= !((state_q == SBI_ACK1) || (state_q == SBI_ACK2));
            if (state_q == SBI_ACK1)
                xfer_ack_out <= err_q ? `SBI_ACK_ERR : `SBI_ACK_WORD;
            else
                xfer_ack_out <= `SBI_ACK_IDLE; // idle code in the release cycle
            bus_data_out <= rdata_q;
            bus_data_oe_n <= !(state_q == SBI_ACK2 && rd_q && !err_q);
        end
    end

    // vertical_blank_event: rising edge sets the request; bus reset or a low vertical_blank_event clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vertical_blank_event_irq_oe_n <= 1'b1;
            vertical_blank_event_irq_out <= 1'b0;
        end else begin
            vertical_blank_event_irq_out <= 1'b0;
            if (vb_s_q[1] & ~vb_d1_q)
                vertical_blank_event_irq_oe_n <= 1'b0;
            else if (bus_rst || (!vb_s_q[1] && !vb_d1_q))
                vertical_blank_event_irq_oe_n <= 1'b1;
        end
    end
endmodule : sbi_slave
`default_nettype wire

// >>> test/sbi_checker.sv
// Purpose: port-level assertions for the bus slave interface
// Assumes: 200 MHz clk, 80 ns bus clock
// Notes: bound to sbi_slave below
`timescale 1ns/10ps
`default_nettype none
module sbi_checker (
    input wire logic clk, // core clock
    input wire logic rst_n, // reset, active low
    input wire logic slave_select_in, // select
    input wire logic addr_strobe_in, // strobe
    input wire logic read_not_write_in, // direction
    input wire logic [2:0] xfer_size_in, // size code
    input wire logic bus_data_oe_n, // data enable
    input wire logic [2:0] xfer_ack_out, // ack code
    input wire logic xfer_ack_oe_n, // ack enable
    input wire logic vertical_blank_event, // vertical_blank_event level
    input wire logic vertical_blank_event_irq_out, // irq value
    input wire logic vertical_blank_event_irq_oe_n // irq enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] win_q;
    // drive window length; two bus cycles are 32 clk, sync jitter allows a little more
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) win_q <= 8'h0;
        else if (xfer_ack_oe_n) win_q <= 8'h0;
        else win_q <= win_q + 8'h1;
    end
    chk_ack_window_max: assert property (win_q <= 8'h22)
        else $error("ack driven too long");
    chk_ack_window_min: assert property ($rose(xfer_ack_oe_n) |-> win_q >= 8'h1e)
        else $error("ack window too short");
    chk_ack_first_code: assert property ($fell(xfer_ack_oe_n) |->
        xfer_ack_out inside {3'h4, 3'h5}) else $error("bad first ack code");
    chk_ack_when_sel: assert property ($fell(xfer_ack_oe_n) |->
        slave_select_in && addr_strobe_in) else $error("ack without select");
    chk_burst_err: assert property ($fell(xfer_ack_oe_n) && xfer_size_in inside {[3'h4:3'h6]}
        |-> xfer_ack_out == 3'h5) else $error("burst not refused");
    chk_data_on_read: assert property (!bus_data_oe_n |->
        !xfer_ack_oe_n && read_not_write_in) else $error("data driven off read");
    chk_irq_raise: assert property ($rose(vertical_blank_event) |-> ##[1:8] !vertical_blank_event_irq_oe_n)
        else $error("irq not raised");
    chk_irq_drop: assert property ($fell(vertical_blank_event) |-> ##[1:8] vertical_blank_event_irq_oe_n)
        else $error("irq not released");
    chk_irq_level: assert property (!vertical_blank_event_irq_oe_n |-> !vertical_blank_event_irq_out)
        else $error("irq pulls high");
endmodule : sbi_checker
bind sbi_slave sbi_checker u_chk (.clk(clk), .rst_n(rst_n), .slave_select_in(slave_select_in),
    .addr_strobe_in(addr_strobe_in), .read_not_write_in(read_not_write_in),
    .xfer_size_in(xfer_size_in), .bus_data_oe_n(bus_data_oe_n), .xfer_ack_out(xfer_ack_out),
    .xfer_ack_oe_n(xfer_ack_oe_n), .vertical_blank_event(vertical_blank_event),
    .vertical_blank_event_irq_out(vertical_blank_event_irq_out), .vertical_blank_event_irq_oe_n(vertical_blank_event_irq_oe_n));
`default_nettype wire

// >>> test/sbi_host_model.sv
// Purpose: bus master issuing single accesses
// Assumes: free-running 80 ns bus clock, pull-ups on address and data
// Notes: access returns 3'h7 when no ack came
`timescale 1ns/10ps
`default_nettype none
module sbi_host_model (
    output logic bus_clock_in, // bus clock
    output logic slave_select_in, // select
    output logic addr_strobe_in, // strobe
    output logic read_not_write_in, // direction
    output logic [2:0] xfer_size_in, // size
    output logic [23:0] bus_addr_in, // address
    output logic [31:0] bus_data_in, // resolved data wire
    input wire logic [31:0] bus_data_out, // device data
    input wire logic bus_data_oe_n, // device data enable
    input wire logic [2:0] xfer_ack_out, // ack code
    input wire logic xfer_ack_oe_n // ack enable
);
    logic [31:0] wdat;
    logic wdrv;
    // bus clock runs free, symmetric
    initial bus_clock_in = 1'h0;
    always #40 bus_clock_in = ~bus_clock_in;
    // pull-ups win when nobody drives
    assign bus_data_in = !bus_data_oe_n ? bus_data_out : (wdrv ? wdat : 32'hffffffff);
    initial begin
        // write data is not driven at idle, so the data lines rest at the pull-up level
        {slave_select_in, addr_strobe_in, read_not_write_in, wdrv} = 4'ha;
        xfer_size_in = 3'h7;
        bus_addr_in = 24'hffffff;
    end
    // one single access, held until the ack has been taken
    task automatic access(input logic sel, rnw, input logic [2:0] siz, input logic [23:0] a,
        input logic [31:0] d, output logic [2:0] code, output logic [31:0] q);
        @(posedge bus_clock_in);
        #2;
        slave_select_in = sel;
        addr_strobe_in = 1'h1;
        read_not_write_in = rnw;
        xfer_size_in = siz;
        bus_addr_in = a;
        wdat = d;
        wdrv = !rnw;
        code = 3'h7;
        q = 32'h0;
        for (int n = 0; n < 24 && code === 3'h7; n++) begin
            @(posedge bus_clock_in);
            if (!xfer_ack_oe_n) code = xfer_ack_out;
        end
        @(posedge bus_clock_in);
        q = bus_data_in;
        #2;
        {slave_select_in, addr_strobe_in, wdrv} = 3'h0;
        bus_addr_in = 24'hffffff;
        repeat (2) @(posedge bus_clock_in);
    endtask : access
endmodule : sbi_host_model
`default_nettype wire

// >>> test/sbi_slave_tb.sv
// Purpose: self-checking bench for sbi_slave
// Assumes: host model makes the bus side
// Notes: one task per scenario
`timescale 1ns/10ps
`default_nettype none
module sbi_slave_tb;
    logic clk, rst_n, bus_reset_in, vertical_blank_event, bus_clock_in, slave_select_in;
    logic addr_strobe_in, read_not_write_in, bus_data_oe_n, xfer_ack_oe_n;
    logic vertical_blank_event_irq_out, vertical_blank_event_irq_oe_n;
    logic [2:0] xfer_size_in, xfer_ack_out, monitor_sense_code, c;
    logic [23:0] bus_addr_in;
    logic [31:0] bus_data_in, bus_data_out, q;
    int error_cnt = 0;
    int compares = 0;
    sbi_slave uut (.clk(clk), .rst_n(rst_n), .bus_clock_in(bus_clock_in),
        .bus_reset_in(bus_reset_in), .slave_select_in(slave_select_in),
        .addr_strobe_in(addr_strobe_in), .read_not_write_in(read_not_write_in),
        .xfer_size_in(xfer_size_in), .bus_addr_in(bus_addr_in), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
        .xfer_ack_out(xfer_ack_out), .xfer_ack_oe_n(xfer_ack_oe_n),
        .vertical_blank_event(vertical_blank_event), .vertical_blank_event_irq_out(vertical_blank_event_irq_out),
        .vertical_blank_event_irq_oe_n(vertical_blank_event_irq_oe_n), .monitor_sense_code(monitor_sense_code));
    sbi_host_model host (.bus_clock_in(bus_clock_in), .slave_select_in(slave_select_in),
        .addr_strobe_in(addr_strobe_in), .read_not_write_in(read_not_write_in),
        .xfer_size_in(xfer_size_in), .bus_addr_in(bus_addr_in), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
        .xfer_ack_out(xfer_ack_out), .xfer_ack_oe_n(xfer_ack_oe_n));
    // 200 MHz core clock
    always #2.5 clk = ~clk;
    task automatic chk(input logic [31:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test;
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic t_rw;
        host.access(1'h1, 1'h0, 3'h0, 24'h000004, 32'hdeadbeef, c, q);
        chk(32'(c), 32'h4, "write ack");
        host.access(1'h1, 1'h0, 3'h0, 24'h000008, 32'h12345678, c, q);
        chk(32'(c), 32'h4, "write ack 8");
        host.access(1'h1, 1'h1, 3'h0, 24'h000004, 32'h0, c, q);
        chk(q, 32'hdeadbeef, "read word 4");
        host.access(1'h1, 1'h1, 3'h0, 24'h000008, 32'h0, c, q);
        chk(q, 32'h12345678, "read word 8");
    endtask : t_rw
    task automatic t_burst;
        for (int s = 4; s < 7; s++) begin
            host.access(1'h1, 1'h0, 3'(s), 24'h000004, 32'h0, c, q);
            chk(32'(c), 32'h5, "burst ack");
        end
        host.access(1'h1, 1'h1, 3'h0, 24'h000004, 32'h0, c, q);
        chk(q, 32'hdeadbeef, "word after burst");
    endtask : t_burst
    task automatic t_nosel;
        host.access(1'h0, 1'h0, 3'h4, 24'h000004, 32'h0, c, q);
        chk(32'(c), 32'h7, "unselected ack");
    endtask : t_nosel
    task automatic t_sense;
        @(posedge clk) monitor_sense_code <= 3'h5;
        host.access(1'h1, 1'h1, 3'h0, 24'h000000, 32'h0, c, q);
        chk(32'(q[2:0]), 32'h5, "sense code");
    endtask : t_sense
    task automatic t_irq;
        @(posedge clk) vertical_blank_event <= 1'h1;
        repeat (10) @(posedge clk);
        chk(32'(vertical_blank_event_irq_oe_n), 32'h0, "irq pulled");
        vertical_blank_event <= 1'h0;
        repeat (10) @(posedge clk);
        chk(32'(vertical_blank_event_irq_oe_n), 32'h1, "irq released");
    endtask : t_irq
    task automatic t_breset;
        @(posedge clk) bus_reset_in <= 1'h1;
        repeat (48) @(posedge clk);
        bus_reset_in <= 1'h0;
        host.access(1'h1, 1'h1, 3'h0, 24'h000004, 32'h0, c, q);
        chk(32'(c), 32'h4, "ack after bus reset");
    endtask : t_breset
    initial begin
        {clk, rst_n, bus_reset_in, vertical_blank_event} = 4'h0;
        monitor_sense_code = 3'h2;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        repeat (8) @(posedge clk);
        t_rw();
        t_burst();
        t_nosel();
        t_sense();
        t_irq();
        t_breset();
        end_of_test();
    end
    // watchdog well beyond the expected 8 us
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end
endmodule : sbi_slave_tb
`default_nettype wire
